// [hw/down_timer_cfg.svh]
// Summary of operation
// - Reading the counter register returns the live 8-bit down count.
// - Writing the counter register loads both reload value and running count.
// - The counter counts only while the run bit is one.
// - Non-stop, reload select clear: count continues from 0xff after underflow.
// - Non-stop, reload select set: underflow reloads the stored reload value.
// - One-shot mode counts once down to 0x00 and stops at underflow.
// - Polarity bit one makes the PWM active level low, zero high.
// - Pin enable one drives PWM onto its pin, zero leaves ordinary GPIO.
// - Rate field n selects prescaler division by two to the n plus one.
// - Prescaler disable bit one bypasses the prescaler, zero lets it divide.
// - External source counts on falling edge when edge bit one, else rising.
// - Clock source bit one selects the external pin, zero the instruction clock.
// - PWM stays inactive until count equals duty, then active until underflow.
// - Reload value sets the PWM frame when reload select is set, the write-only duty register the duty.
// - Prescaler readback returns the live prescaler count and is read-only.
// - Buzzer codes 0 to 7 take a prescaler tap dividing 1:2 to 1:256.
// - Buzzer codes 8 to 15 take counter bit given by the low three bits.
// - Buzzer enable bit one turns the buzzer output on, zero off.
// - Each underflow sets the underflow flag until software clears it.
// - The flag reads zero whenever its underflow interrupt enable is clear.
`ifndef DOWN_TIMER_CFG_SVH
`define DOWN_TIMER_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define IDX_COUNTER      3'h0
`define IDX_CTL_ONE      3'h1
`define IDX_CTL_TWO      3'h2
`define IDX_DUTY         3'h3
`define IDX_PRESCALE     3'h4
`define IDX_BUZZER       3'h5
`define IDX_STATUS       3'h6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CR1_RUN_BIT      0
`define CR1_RELOAD_BIT   1
`define CR1_ONESHOT_BIT  2
`define CR1_POL_BIT      6
`define CR1_PINEN_BIT    7
`define CR2_RATE_LSB     0
`define CR2_PSOFF_BIT    3
`define CR2_EDGE_BIT     4
`define CR2_SRC_BIT      5
`define BUZ_FREQ_LSB     0
`define BUZ_ON_BIT       7
`define STAT_FLAG_BIT    0
`define STAT_IE_BIT      1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define COUNTER_RESET    8'h00
`define DUTY_RESET       8'h00
`define CR1_RESET        8'h00
`define CR2_RESET        8'h3f
`define BUZ_RESET        8'h0f
`define PS_RESET         8'hff

`endif

// [hw/down_timer_pkg.sv]
// ----------------------------------------------------------------------------
// Types shared by the timer files
// ----------------------------------------------------------------------------
package down_timer_pkg;

    typedef struct packed {
        logic       pwm_pin_enable;
        logic       pwm_active_low;
        logic       one_shot_select;
        logic       reload_select;
        logic       timer_run;
    } ctl_one_t;

    typedef struct packed {
        logic       clock_source_select;
        logic       ext_edge_select;
        logic       prescale_disable_n;
        logic [2:0] prescale_rate_field;
    } ctl_two_t;

    typedef struct packed {
        logic       buzzer_on;
        logic [3:0] buzzer_freq_field;
    } buzz_ctl_t;

endpackage : down_timer_pkg

// [hw/source_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module source_tick (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clock_source_select,
    input  wire logic ext_edge_select,
    input  wire logic external_clock_pin,
    output logic      tick
);
    logic pin_prev_r;
    logic rise;
    logic fall;

    always_ff @(posedge core_clk) begin
        // Following the pin during reset keeps a high idle level from looking like an edge.
        if (!reset_n) begin
            pin_prev_r <= external_clock_pin;
        end else begin
            pin_prev_r <= external_clock_pin;
        end
    end

    assign rise = external_clock_pin & ~pin_prev_r;
    assign fall = ~external_clock_pin & pin_prev_r;

    assign tick = clock_source_select ? (ext_edge_select ? fall : rise) : 1'b1;
endmodule : source_tick
`default_nettype wire

// [hw/prescale_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "down_timer_cfg.svh"
module prescale_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             src_tick,
    input  wire logic             bypass,
    input  wire logic [2:0]       rate,
    output logic      [WIDTH-1:0] count_r,
    output logic                  term_tick
);
    logic [WIDTH:0]   mask_wide;
    logic [WIDTH-1:0] count_inc;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            count_r <= WIDTH'(`PS_RESET);
        end else if (src_tick && !bypass) begin
            count_r <= count_inc;
        end
    end

    assign count_inc = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    // divide by two to the rate plus one
    assign mask_wide = ({{(WIDTH-1){1'b0}}, 2'b10} << rate) - {{WIDTH{1'b0}}, 1'b1};
    assign term_tick = src_tick && !bypass && ((count_inc & mask_wide[WIDTH-1:0]) == '0);
endmodule : prescale_counter
`default_nettype wire

// [hw/down_timer_pwm_buzzer.sv]
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "down_timer_cfg.svh"
module down_timer_pwm_buzzer #(
    parameter int AW = 12
) (
    input  wire logic          core_clk,
    input  wire logic          reset_n,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          external_clock_pin,
    input  wire logic          gpio_out,
    input  wire logic          gpio_oe_n,
    output logic               pwm_port_pin,
    output logic               pwm_port_pin_oe_n,
    output logic               buzzer_output
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    down_timer_pkg::ctl_one_t  ctl1_r;
    down_timer_pkg::ctl_two_t  ctl2_r;
    down_timer_pkg::buzz_ctl_t buzz_r;
    logic [7:0]                count_r;
    logic [7:0]                reload_r;
    logic [7:0]                duty_r;
    logic [7:0]                ps_count;
    logic                      underflow_flag_r;
    logic                      underflow_irq_enable_r;
    logic                      shot_done_r;
    logic                      pwm_active_r;
    logic [31:0]               prdata_r;
    logic                      pready_r;
    logic                      pslverr_r;
    logic                      pwm_port_pin_r;
    logic                      pwm_port_pin_oe_n_r;
    logic                      buzzer_output_r;

    // ------------------------------------------------------------------------
    // Unpacking helpers
    // ------------------------------------------------------------------------
    function automatic down_timer_pkg::ctl_one_t to_ctl1(input logic [7:0] b);
        down_timer_pkg::ctl_one_t c;
        c.pwm_pin_enable  = b[`CR1_PINEN_BIT];
        c.pwm_active_low  = b[`CR1_POL_BIT];
        c.one_shot_select = b[`CR1_ONESHOT_BIT];
        c.reload_select   = b[`CR1_RELOAD_BIT];
        c.timer_run       = b[`CR1_RUN_BIT];
        return c;
    endfunction : to_ctl1

    function automatic down_timer_pkg::ctl_two_t to_ctl2(input logic [7:0] b);
        down_timer_pkg::ctl_two_t c;
        c.clock_source_select = b[`CR2_SRC_BIT];
        c.ext_edge_select     = b[`CR2_EDGE_BIT];
        c.prescale_disable_n  = b[`CR2_PSOFF_BIT];
        c.prescale_rate_field = b[`CR2_RATE_LSB +: 3];
        return c;
    endfunction : to_ctl2

    function automatic down_timer_pkg::buzz_ctl_t to_buzz(input logic [7:0] b);
        down_timer_pkg::buzz_ctl_t c;
        c.buzzer_on         = b[`BUZ_ON_BIT];
        c.buzzer_freq_field = b[`BUZ_FREQ_LSB +: 4];
        return c;
    endfunction : to_buzz

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic [2:0] reg_idx;
    logic       addr_ok;
    logic       setup_phase;
    logic       access_done;
    logic       wr_ok;
    logic       wr_counter;
    logic       wr_ctl1;
    logic       wr_ctl2;
    logic       wr_duty;
    logic       wr_buzz;
    logic       wr_status;
    logic [31:0] read_word;

    assign reg_idx     = paddr[4:2];
    assign addr_ok     = (paddr[1:0] == 2'h0) && (paddr[AW-1:5] == '0)
                         && (reg_idx <= `IDX_STATUS);
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_r;
    // Byte lane zero carries every register, so a write without it changes nothing.
    assign wr_ok       = access_done && pwrite && !pslverr_r && pstrb[0];
    assign wr_counter  = wr_ok && (reg_idx == `IDX_COUNTER);
    assign wr_ctl1     = wr_ok && (reg_idx == `IDX_CTL_ONE);
    assign wr_ctl2     = wr_ok && (reg_idx == `IDX_CTL_TWO);
    assign wr_duty     = wr_ok && (reg_idx == `IDX_DUTY);
    assign wr_buzz     = wr_ok && (reg_idx == `IDX_BUZZER);
    assign wr_status   = wr_ok && (reg_idx == `IDX_STATUS);

    always_comb begin
        read_word = 32'h0000_0000;
        unique case (reg_idx)
            `IDX_COUNTER: begin
                read_word[7:0] = count_r;
            end
            `IDX_CTL_ONE: begin
                read_word[`CR1_ONESHOT_BIT] = ctl1_r.one_shot_select;
                read_word[`CR1_RELOAD_BIT]  = ctl1_r.reload_select;
                read_word[`CR1_RUN_BIT]     = ctl1_r.timer_run;
            end
            `IDX_CTL_TWO: begin
                read_word[`CR2_SRC_BIT]        = ctl2_r.clock_source_select;
                read_word[`CR2_EDGE_BIT]       = ctl2_r.ext_edge_select;
                read_word[`CR2_PSOFF_BIT]      = ctl2_r.prescale_disable_n;
                read_word[`CR2_RATE_LSB +: 3]  = ctl2_r.prescale_rate_field;
            end
            `IDX_PRESCALE: begin
                read_word[7:0] = ps_count;
            end
            `IDX_STATUS: begin
                read_word[`STAT_FLAG_BIT] = underflow_flag_r && underflow_irq_enable_r;
                read_word[`STAT_IE_BIT]   = underflow_irq_enable_r;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // A fixed one-wait-state answer keeps the slave free of any stall logic.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup_phase;
            pslverr_r <= setup_phase && !addr_ok;
            if (setup_phase && !pwrite && addr_ok) begin
                prdata_r <= read_word;
            end else if (setup_phase) begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctl1_r <= to_ctl1(`CR1_RESET);
            ctl2_r <= to_ctl2(`CR2_RESET);
            buzz_r <= to_buzz(`BUZ_RESET);
            duty_r <= `DUTY_RESET;
            underflow_irq_enable_r <= 1'b0;
        end else begin
            if (wr_ctl1) begin
                ctl1_r <= to_ctl1(pwdata[7:0]);
            end
            // rate written freely, software keeps it safe
            if (wr_ctl2) begin
                ctl2_r <= to_ctl2(pwdata[7:0]);
            end
            if (wr_buzz) begin
                buzz_r <= to_buzz(pwdata[7:0]);
            end
            if (wr_duty) begin
                duty_r <= pwdata[7:0];
            end
            if (wr_status) begin
                underflow_irq_enable_r <= pwdata[`STAT_IE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------------
    logic       src_tick;
    logic       ps_term;
    logic       dec_tick;
    logic       dec_en;
    logic       underflow;

    source_tick u_source_tick (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .clock_source_select (ctl2_r.clock_source_select),
        .ext_edge_select     (ctl2_r.ext_edge_select),
        .external_clock_pin  (external_clock_pin),
        .tick                (src_tick)
    );

    prescale_counter #(
        .WIDTH (8)
    ) u_prescale (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .src_tick (src_tick),
        .bypass   (ctl2_r.prescale_disable_n),
        .rate     (ctl2_r.prescale_rate_field),
        .count_r  (ps_count),
        .term_tick(ps_term)
    );

    assign dec_tick  = ctl2_r.prescale_disable_n ? src_tick : ps_term;
    assign dec_en    = ctl1_r.timer_run && dec_tick && !shot_done_r;
    assign underflow = dec_en && (count_r == 8'h00);

    // ------------------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            count_r  <= `COUNTER_RESET;
            reload_r <= `COUNTER_RESET;
        end else if (wr_counter) begin
            count_r  <= pwdata[7:0];
            reload_r <= pwdata[7:0];
        end else if (underflow) begin
            if (ctl1_r.one_shot_select) begin
                count_r <= 8'h00;
            end else if (ctl1_r.reload_select) begin
                count_r <= reload_r;
            end else begin
                count_r <= 8'hff;
            end
        end else if (dec_en) begin
            count_r <= count_r - 8'h01;
        end
    end

    // A new count or a fresh write to control register one re-arms a finished one-shot run.
    // one-shot stop latch
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            shot_done_r <= 1'b0;
        end else if (wr_counter || wr_ctl1) begin
            shot_done_r <= 1'b0;
        end else if (underflow && ctl1_r.one_shot_select) begin
            shot_done_r <= 1'b1;
        end
    end

    // sticky flag, set wins over clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            underflow_flag_r <= 1'b0;
        end else if (underflow) begin
            underflow_flag_r <= 1'b1;
        end else if (wr_status && pwdata[`STAT_FLAG_BIT]) begin
            underflow_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // PWM
    // ------------------------------------------------------------------------
    // inactive until duty match, active until underflow
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pwm_active_r <= 1'b0;
        end else if (!ctl1_r.timer_run || underflow) begin
            pwm_active_r <= 1'b0;
        end else if (count_r == duty_r) begin
            pwm_active_r <= 1'b1;
        end
    end

    // The match cycle itself is already active, so the latch alone would lose one cycle.
    // active from match
    logic pwm_level;
    assign pwm_level = ctl1_r.timer_run && (pwm_active_r || (count_r == duty_r));

    // The pin follows the PWM state one cycle later; both edges shift alike.
    // polarity
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pwm_port_pin_r      <= 1'b0;
            pwm_port_pin_oe_n_r <= 1'b1;
        end else if (ctl1_r.pwm_pin_enable) begin
            pwm_port_pin_r      <= pwm_level ^ ctl1_r.pwm_active_low;
            pwm_port_pin_oe_n_r <= 1'b0;
        end else begin
            pwm_port_pin_r      <= gpio_out;
            pwm_port_pin_oe_n_r <= gpio_oe_n;
        end
    end

    // ------------------------------------------------------------------------
    // Buzzer
    // ------------------------------------------------------------------------
    logic buzz_tap;

    assign buzz_tap = buzz_r.buzzer_freq_field[3] ? count_r[buzz_r.buzzer_freq_field[2:0]]
                                                  : ps_count[buzz_r.buzzer_freq_field[2:0]];

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            buzzer_output_r <= 1'b0;
        end else begin
            buzzer_output_r <= buzz_r.buzzer_on && buzz_tap;
        end
    end

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign pwm_port_pin      = pwm_port_pin_r;
    assign pwm_port_pin_oe_n = pwm_port_pin_oe_n_r;
    assign buzzer_output     = buzzer_output_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence wrap_underflow_s;
        underflow && !wr_counter && !ctl1_r.one_shot_select;
    endsequence

    apb_answer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        apb_setup_s |=> pready_r ##1 !pready_r)
        else $error("slave did not answer after one wait state");

    counter_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_counter |=> (count_r == $past(pwdata[7:0])) && (reload_r == count_r))
        else $error("counter write did not load count and reload");

    halt_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!ctl1_r.timer_run && !wr_counter) |=> $stable(count_r))
        else $error("counter moved while halted");

    wrap_ff_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wrap_underflow_s and !ctl1_r.reload_select) |=> count_r == 8'hff)
        else $error("non-stop underflow did not wrap to all ones");

    reload_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wrap_underflow_s and ctl1_r.reload_select) |=> count_r == $past(reload_r))
        else $error("underflow did not reload stored value");

    shot_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (underflow && ctl1_r.one_shot_select && !wr_counter && !wr_ctl1)
        |=> (shot_done_r && count_r == 8'h00) ##1 (count_r == 8'h00 || $past(wr_counter)))
        else $error("one-shot did not stop at zero");

    pwm_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ctl1_r.pwm_pin_enable && $stable(ctl1_r)) |=>
        !pwm_port_pin_oe_n_r
        && (pwm_port_pin_r == ($past(pwm_level) ^ $past(ctl1_r.pwm_active_low))))
        else $error("enabled pin does not show PWM with its polarity");

    pwm_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        underflow |=> !pwm_active_r)
        else $error("PWM stayed active past underflow");

    flag_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        underflow |=> underflow_flag_r
        ##1 (underflow_flag_r || $past(wr_status && pwdata[`STAT_FLAG_BIT])))
        else $error("underflow did not set a sticky flag");

    flag_mask_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (setup_phase && !pwrite && reg_idx == `IDX_STATUS && !underflow_irq_enable_r)
        |=> !prdata_r[`STAT_FLAG_BIT])
        else $error("flag read as one with its enable clear");

    buzz_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !buzz_r.buzzer_on |=> !buzzer_output_r)
        else $error("buzzer sounded while disabled");

endmodule : down_timer_pwm_buzzer
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
// ----------------------------------------------------------------------------
// Harness
// ----------------------------------------------------------------------------
typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_t;
logic core_clk, reset_n, psel, penable, pwrite, ext, gpio_out, gpio_oe_n, e;
logic pready, pslverr, pin, pin_oe_n, buzz;
logic [11:0] paddr;
logic [31:0] pwdata, prdata;
logic [3:0] pstrb;
logic [7:0] q, q2;
int num_errors, n_tests, hi, tg;
row_t rows [16] = '{'{0,12'h000,8'h00,8'h00}, '{0,12'h004,8'h00,8'h00},
    '{0,12'h008,8'h00,8'h3f}, '{0,12'h00c,8'h00,8'h00}, '{0,12'h010,8'h00,8'hff},
    '{0,12'h014,8'h00,8'h00}, '{0,12'h018,8'h00,8'h00}, '{1,12'h00c,8'h55,8'h00},
    '{0,12'h00c,8'h00,8'h00}, '{1,12'h010,8'h12,8'h00}, '{0,12'h010,8'h00,8'hff},
    '{1,12'h004,8'hc0,8'h00}, '{0,12'h004,8'h00,8'h00}, '{1,12'h004,8'h00,8'h00},
    '{1,12'h008,8'h08,8'h00}, '{0,12'h008,8'h00,8'h08}};
down_timer_pwm_buzzer dut_u (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_clock_pin(ext),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .pwm_port_pin(pin),
    .pwm_port_pin_oe_n(pin_oe_n), .buzzer_output(buzz));
initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
end
task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
        @(posedge core_clk);
        t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata[7:0];
    e = pslverr;
    if (pready !== 1'b1) begin
        num_errors++;
        $display("Error at %0t: pready %h, expected %h", $time, pready, 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
endtask : apb
task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hv);
    n_tests++;
    if ((got >= lo && got <= hv) !== 1'b1) begin
        num_errors++;
        $display("Error at %0t: got %h, expected %h to %h", $time, got, lo, hv);
    end
endtask : rng
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    rng(got, exp, exp);
endtask : chk
task automatic meas(input int n);
    logic pb;
    hi = 0;
    tg = 0;
    repeat (2) @(negedge core_clk);
    pb = buzz;
    repeat (n) begin
        @(negedge core_clk);
        if (pin === 1'b1) hi++;
        if (buzz !== pb) tg++;
        pb = buzz;
    end
endtask : meas
task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask : summarize
// The whole sequence needs under a thousand cycles, so this limit only trips on a hang.
initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize();
end
// ----------------------------------------------------------------------------
// Sequence
// ----------------------------------------------------------------------------
initial begin
    {reset_n, psel, penable, pwrite, ext, gpio_out, gpio_oe_n} = 7'h01;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
        apb(rows[i].wr, rows[i].a, rows[i].d);
        if (!rows[i].wr) chk(q, rows[i].e);
    end
    apb(0, 12'h01c, 8'h00);
    chk({7'h0, e}, 8'h01);
    chk(q, 8'h00);
    $display("Test registers done");
    for (int r = 0; r < 4; r++) begin
        apb(1, 12'h008, 8'h08 | r[7:0]);
        apb(1, 12'h008, (r == 3) ? 8'h08 : r[7:0]);
        apb(1, 12'h000, 8'h80);
        apb(1, 12'h004, 8'h01);
        apb(0, 12'h000, 8'h00);
        q2 = q;
        repeat (40) @(posedge core_clk);
        apb(0, 12'h000, 8'h00);
        q2 = q2 - q;
        rng(q2, (r == 3) ? 8'd43 : 8'(43 >> (r + 1)),
            (r == 3) ? 8'd43 : 8'((43 >> (r + 1)) + 1));
        apb(1, 12'h004, 8'h00);
    end
    apb(1, 12'h008, 8'h08);
    apb(1, 12'h000, 8'h03);
    repeat (10) @(posedge core_clk);
    apb(0, 12'h000, 8'h00);
    chk(q, 8'h03);
    for (int m = 0; m < 2; m++) begin
        apb(1, 12'h000, 8'h03);
        apb(1, 12'h004, 8'h01 | (m[7:0] << 1));
        repeat (10) @(posedge core_clk);
        apb(1, 12'h004, 8'h00);
        apb(0, 12'h000, 8'h00);
        rng(q, m ? 8'h00 : 8'h04, m ? 8'h03 : 8'hff);
    end
    apb(1, 12'h000, 8'h05);
    apb(1, 12'h004, 8'h05);
    repeat (20) @(posedge core_clk);
    apb(0, 12'h000, 8'h00);
    chk(q, 8'h00);
    apb(0, 12'h018, 8'h00);
    chk(q, 8'h00);
    apb(1, 12'h018, 8'h02);
    apb(0, 12'h018, 8'h00);
    chk(q, 8'h03);
    apb(1, 12'h018, 8'h03);
    apb(0, 12'h018, 8'h00);
    chk(q, 8'h02);
    $display("Test counting done");
    for (int m = 0; m < 2; m++) begin
        ext <= 1'b0;
        apb(1, 12'h008, 8'h28 | (m[7:0] << 4));
        apb(1, 12'h000, 8'h40);
        apb(1, 12'h004, 8'h01);
        repeat (5) begin
            repeat (3) @(posedge core_clk);
            ext <= ~ext;
        end
        repeat (3) @(posedge core_clk);
        apb(1, 12'h004, 8'h00);
        apb(0, 12'h000, 8'h00);
        chk(q, 8'h3d + m[7:0]);
    end
    $display("Test external clock done");
    gpio_out <= 1'b1;
    gpio_oe_n <= 1'b0;
    apb(1, 12'h008, 8'h08);
    chk({6'h0, pin, pin_oe_n}, 8'h02);
    gpio_oe_n <= 1'b1;
    apb(1, 12'h00c, 8'h01);
    apb(1, 12'h000, 8'h05);
    for (int m = 0; m < 2; m++) begin
        apb(1, 12'h004, m ? 8'hc3 : 8'h83);
        meas(60);
        rng(hi[7:0], m ? 8'd39 : 8'd19, m ? 8'd41 : 8'd21);
        chk({7'h0, pin_oe_n}, 8'h00);
    end
    $display("Test pwm done");
    apb(1, 12'h004, 8'h01);
    apb(1, 12'h008, 8'h00);
    for (int m = 0; m < 4; m++) begin
        apb(1, 12'h014, (m == 0) ? 8'h80 : (m == 1) ? 8'h88 : (m == 2) ? 8'h89 : 8'h08);
        meas(40);
        rng(tg[7:0], (m == 3) ? 8'd0 : 8'((40 >> m) - 1),
            (m == 3) ? 8'd0 : 8'((40 >> m) + 1));
    end
    $display("Test buzzer done");
    summarize();
end
endmodule : testbench
`default_nettype wire
